// file: hdl/scp_defs.svh
// Purpose: Constants for the serial configuration port
// Assumes: 50 MHz core clock
// Notes:   Bit positions and counts only
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_HDR_RW_BIT     7
`define SCP_HDR_BURST_BIT  6
`define SCP_ADDR_MSB       5
`define SCP_BITS_PER_BYTE  4'h8
`define SCP_FIFO_DEPTH     4
`define SCP_DATA_W         8
`endif

// file: hdl/scp_pkg.sv
// Purpose: Types for the serial configuration port
// Assumes: Widths are written out here to match the included defs
// Notes:   Only types live here
`include "scp_defs.svh"
package scp_pkg;
	// Decoded header byte
	typedef struct packed {
		logic       rd;
		logic       burst;
		logic [5:0] addr;
	} scp_hdr_s;
	// One register access toward the core
	typedef struct packed {
		logic       rd;
		logic [5:0] addr;
		logic [7:0] data;
	} scp_acc_s;
	typedef enum logic [1:0] {
		SCP_IDLE,
		SCP_HDR,
		SCP_DATA
	} scp_state_e;
endpackage

// file: hdl/scp_fifo.sv
// Purpose: Small valid/ready FIFO for write accesses
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read data come from a register
`timescale 1ns/10ps
module scp_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk, // Core clock
	input  wire logic             rst_b,    // Sync reset, low
	input  wire logic [WIDTH-1:0] inData,   // Fill data
	input  wire logic             inValid,  // Fill valid
	output logic                  inReady,  // Not full
	output logic      [WIDTH-1:0] outData,  // Drain data
	output logic                  outValid, // Not empty
	input  wire logic             outReady  // Drain accepts
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
	logic [WIDTH-1:0] out_q, out_d;
	logic             push, pop;

	// Pointers and full/empty from the extra wrap bit
	always_comb begin
		inReady  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
		outValid = (wr_q != rd_q);
		push     = inValid && inReady;
		pop      = outValid && outReady;
		wr_d     = push ? wr_q + 1'b1 : wr_q;
		rd_d     = pop ? rd_q + 1'b1 : rd_q;
		out_d    = mem_q[rd_d[AW-1:0]];
		if (push && (wr_q[AW-1:0] == rd_d[AW-1:0])) begin
			out_d = inData;
		end
	end
	assign outData = out_q;

	// Pointer and output registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			out_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			out_q <= out_d;
		end
	end

	// Storage entries
	for (genvar i = 0; i < DEPTH; i++) begin : gEnt
		always_ff @(posedge core_clk) begin
			if (push && (wr_q[AW-1:0] == AW'(i))) begin
				mem_q[i] <= inData;
			end
		end
	end
endmodule

// file: hdl/scp_port.sv
// Purpose: Four-wire serial slave port for config and buffered data
// Assumes: Link clock far slower than core clock; sampled, not used as clock
// Notes:   Writes go out through a FIFO; reads use a one-cycle lookup
`timescale 1ns/10ps
`include "scp_defs.svh"
// Operation
// R01: All bytes shift most significant bit first
// R02: Host opens each transaction with header byte
// R03: Header bit7 read, bit6 burst, 5:0 address
// R04: Read flag one reads, zero writes
// R05: Host keeps select low whole transfer
// R06: Select rising midway abandons the transfer
// R07: Host waits for data-out low first
// R08: Data-out low only once oscillator runs
// R09: Oscillator running: data-out low at select
// R10: Host up to 10 MHz with gaps
// R11: Single access without gap: 9 MHz max
// R12: Burst access without gaps: 6.5 MHz max
// R13: Blind host waits 150 us from select
// R14: Registers default on reset, host rewrites
// R15: Same port carries registers and buffered data
// R16: Sample input rising, change output falling
// R17: Status byte shifts out during header
// R18: Burst address increments every eight clocks
module scp_port (
	input  wire logic        core_clk,     // Core clock, 50 MHz
	input  wire logic        rst_b,        // Sync reset, low
	input  wire logic        serialClk,    // Link clock pin
	input  wire logic        chip_select_low, // Select pin, low
	input  wire logic        serialIn,     // Data in pin
	output logic             serialOut,    // Data out pin
	output logic             serialOutEn,  // Data out driven
	input  wire logic        oscRunning,   // Crystal oscillator stable
	input  wire logic [7:0]  statusByte,   // Status shifted with header
	output scp_pkg::scp_acc_s wrAcc,       // Write access to core
	output logic             wrValid,      // Write access valid
	input  wire logic        wrReady,      // Core takes write
	output logic [5:0]       rdAddr,       // Read address to core
	output logic             rdStrobe,     // Read request pulse
	input  wire logic [7:0]  rdData,       // Read data, next cycle
	output logic             overrun       // Write lost, FIFO full
);
	logic [2:0] sclkSync_q, csSync_q, siSync_q;
	logic       sclkRise, sclkFall, csLow;
	logic       rdReq;
	scp_pkg::scp_state_e st_q, st_d;
	logic [7:0] shIn_q, shIn_d, shOut_q, shOut_d;
	logic [3:0] cnt_q, cnt_d;
	scp_pkg::scp_hdr_s hdr_q, hdr_d;
	logic       rdPend_q, rdPend_d;
	logic       out_q, out_d, oe_q, oe_d;
	logic       push, fifoReady;
	logic [7:0] byteNow;
	scp_pkg::scp_acc_s pushAcc;

	// Three-flop synchronisers; logic reads only stages two and three
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sclkSync_q  <= 3'h0;
			csSync_q    <= 3'h7;
			siSync_q    <= 3'h0;
		end else begin
			sclkSync_q  <= {sclkSync_q[1:0], serialClk};
			csSync_q    <= {csSync_q[1:0], chip_select_low};
			siSync_q    <= {siSync_q[1:0], serialIn};
		end
	end
	assign sclkRise = sclkSync_q[1] && !sclkSync_q[2];
	assign sclkFall = !sclkSync_q[1] && sclkSync_q[2];
	assign csLow    = !csSync_q[1];
	assign byteNow  = {shIn_q[6:0], siSync_q[1]};

	// Transfer state machine
	always_comb begin
		st_d     = st_q;
		shIn_d   = shIn_q;
		shOut_d  = shOut_q;
		cnt_d    = cnt_q;
		hdr_d    = hdr_q;
		rdPend_d = rdStrobe; // Data arrive the cycle after the strobe
		out_d    = out_q;
		oe_d     = oe_q;
		push     = 1'b0;
		pushAcc  = '{rd: 1'b0, addr: hdr_q.addr, data: byteNow};
		rdReq    = 1'b0;
		case (st_q)
			scp_pkg::SCP_IDLE: begin
				oe_d  = 1'b0;
				out_d = 1'b1;
				if (csLow && oscRunning) begin // R08 R09
					st_d    = scp_pkg::SCP_HDR;
					oe_d    = 1'b1;
					out_d   = 1'b0;
					cnt_d   = 4'h0;
					// Ready bit shows at once, the rest follow on falls
					shOut_d = {statusByte[6:0], 1'b0}; // R17
				end else if (csLow) begin
					oe_d = 1'b1; // Ready stays high until crystal runs
				end
			end
			scp_pkg::SCP_HDR, scp_pkg::SCP_DATA: begin
				if (sclkRise) begin // R16
					shIn_d = byteNow; // R01
					cnt_d  = cnt_q + 4'h1;
					if (cnt_q + 4'h1 == `SCP_BITS_PER_BYTE) begin
						cnt_d = 4'h0;
						if (st_q == scp_pkg::SCP_HDR) begin
							hdr_d.rd    = byteNow[`SCP_HDR_RW_BIT]; // R03 R04
							hdr_d.burst = byteNow[`SCP_HDR_BURST_BIT];
							hdr_d.addr  = byteNow[`SCP_ADDR_MSB:0];
							st_d        = scp_pkg::SCP_DATA;
							if (byteNow[`SCP_HDR_RW_BIT]) begin
								rdReq = 1'b1;
							end
						end else begin
							if (!hdr_q.rd) begin // R15
								push = 1'b1;
							end
							if (hdr_q.burst) begin // R18
								hdr_d.addr = hdr_q.addr + 6'h01;
								rdReq      = hdr_q.rd;
							end
						end
					end
				end
				if (sclkFall) begin // R16
					shOut_d = {shOut_q[6:0], 1'b0}; // R01
					out_d   = shOut_q[7];
					if (st_q == scp_pkg::SCP_DATA && !hdr_q.rd) begin
						shOut_d = {statusByte[6:0], 1'b0};
						out_d   = (cnt_q == 4'h0) ? statusByte[7] : shOut_q[7];
						if (cnt_q != 4'h0) begin
							shOut_d = {shOut_q[6:0], 1'b0};
						end
					end
				end
				if (st_q == scp_pkg::SCP_HDR && cnt_q == 4'h0 && !sclkFall) begin
					out_d = 1'b0; // Ready indication before first bit
				end
				if (rdPend_q) begin
					shOut_d = rdData;
				end
				if (!csLow) begin // R06
					st_d  = scp_pkg::SCP_IDLE;
					oe_d  = 1'b0;
					cnt_d = 4'h0;
					push  = 1'b0;
					rdReq = 1'b0;
				end
			end
			default: begin
				st_d = scp_pkg::SCP_IDLE;
			end
		endcase
	end

	// Register stage; defaults after reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin // R14
			st_q     <= scp_pkg::SCP_IDLE;
			shIn_q   <= 8'h00;
			shOut_q  <= 8'h00;
			cnt_q    <= 4'h0;
			hdr_q    <= '0;
			rdPend_q <= 1'b0;
			rdStrobe <= 1'b0;
			out_q    <= 1'b1;
			oe_q     <= 1'b0;
			overrun  <= 1'b0;
		end else begin
			st_q     <= st_d;
			shIn_q   <= shIn_d;
			shOut_q  <= shOut_d;
			cnt_q    <= cnt_d;
			hdr_q    <= hdr_d;
			rdPend_q <= rdPend_d;
			rdStrobe <= rdReq;
			out_q    <= out_d;
			oe_q     <= oe_d;
			overrun  <= push && !fifoReady;
		end
	end
	assign serialOut   = out_q;
	assign serialOutEn = oe_q;
	assign rdAddr      = hdr_q.addr; // Settled with the registered strobe

	// Write accesses buffered toward the core
	scp_fifo #(
		.WIDTH(15),
		.DEPTH(`SCP_FIFO_DEPTH)
	) uFifo (
		.core_clk(core_clk),
		.rst_b   (rst_b),
		.inData  (pushAcc),
		.inValid (push),
		.inReady (fifoReady),
		.outData (wrAcc),
		.outValid(wrValid),
		.outReady(wrReady)
	);

	// Select falling drives out low at once when crystal runs
	rdyLow_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R09
		(st_q == scp_pkg::SCP_IDLE && csLow && oscRunning)
		|=> (serialOutEn && !serialOut))
		else $error("ready low missing after select");
	// Never signal ready without the crystal
	noOsc_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R08
		(st_q == scp_pkg::SCP_IDLE && !oscRunning) |=> serialOut)
		else $error("ready shown without oscillator");
	// Select high abandons the transfer
	abandon_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R06
		(st_q != scp_pkg::SCP_IDLE && !csLow)
		|=> (st_q == scp_pkg::SCP_IDLE && cnt_q == 4'h0 && !serialOutEn))
		else $error("transfer not abandoned");
	// Burst address steps by one per byte
	burstInc_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R18
		(st_q == scp_pkg::SCP_DATA && hdr_q.burst && sclkRise
		&& cnt_q == 4'h7 && csLow)
		|=> hdr_q.addr == $past(hdr_q.addr) + 6'h01)
		else $error("burst address not incremented");
	// Header read flag decoded from the shifted byte
	hdrDec_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R03
		(st_q == scp_pkg::SCP_HDR && sclkRise && cnt_q == 4'h7 && csLow)
		|=> (st_q == scp_pkg::SCP_DATA && hdr_q.rd == shIn_q[7]))
		else $error("header decode wrong");
	// Read header raises one read strobe
	rdReq_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R04
		(st_q == scp_pkg::SCP_HDR && sclkRise && cnt_q == 4'h7
		&& byteNow[7] && csLow) |=> rdStrobe ##1 rdPend_q)
		else $error("read not requested");
	// In the data state, output changes only after a link falling edge
	outEdge_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R16
		(st_q == scp_pkg::SCP_DATA && $past(st_q) == scp_pkg::SCP_DATA
		&& $changed(serialOut)) |-> $past(sclkFall))
		else $error("output moved off falling edge");
	// Write data byte is pushed toward core
	wrPush_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
		(st_q == scp_pkg::SCP_DATA && !hdr_q.rd && sclkRise
		&& cnt_q == 4'h7 && csLow && fifoReady) |=> ##[0:2] wrValid)
		else $error("write byte not buffered");
endmodule

// file: sim/scp_host.sv
// Purpose: Host model that masters the serial port
// Assumes: Link clock halves of 4 core cycles, 160 ns period
// Notes:   Link clock stands low between frames
`timescale 1ns/10ps
module scp_host (
	input  wire logic core_clk,        // Core clock
	output logic      serialClk,       // Link clock
	output logic      chip_select_low, // Select, low
	output logic      serialIn,        // Data toward device
	input  wire logic serialOut,       // Data from device
	input  wire logic serialOutEn      // Device drives data out
);
	// Idle levels at time zero
	initial begin
		serialClk = 1'b0;
		chip_select_low = 1'b1;
		serialIn = 1'b0;
	end
	// Select low, then poll a bounded time for the ready level
	task automatic openFrame(input int tries, output bit ok);
		ok = 1'b0;
		chip_select_low <= 1'b0;
		for (int i = 0; i < tries && !ok; i++) begin
			@(posedge core_clk);
			ok = serialOutEn === 1'b1 && serialOut === 1'b0;
		end
	endtask
	// Data set while clock is low, read just before the rise
	// 160 ns period with no byte gaps keeps under every speed limit
	// A released data line reads as the inverse of its last level
	task automatic shiftByte(input logic [7:0] tx, input int nBits,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int b = 7; b > 7 - nBits; b--) begin
			serialIn <= tx[b];
			repeat (4) @(posedge core_clk);
			serialClk <= 1'b1;
			rx[b] = serialOutEn ? serialOut : ~serialOut;
			repeat (4) @(posedge core_clk);
			serialClk <= 1'b0;
		end
	endtask
	// Select high; data line shows garbage once released
	task automatic closeFrame;
		repeat (4) @(posedge core_clk);
		chip_select_low <= 1'b1;
		serialIn <= ~serialIn;
		repeat (6) @(posedge core_clk);
	endtask
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the serial configuration port
// Assumes: Host model drives the link, bench acts as the core
// Notes:   Read data is a fixed function of the read address
`timescale 1ns/10ps
module tb_top;
	logic              core_clk, rst_b, oscRunning, wrReady;
	logic              serialClk, chip_select_low, serialIn;
	logic              serialOut, serialOutEn, wrValid, rdStrobe, overrun;
	logic [7:0]        rdData, rx, status;
	logic [5:0]        rdAddr;
	scp_pkg::scp_acc_s wrAcc;
	int                miscompares, tests_run, overruns;
	bit                ok;

	scp_port i_dut (.core_clk(core_clk), .rst_b(rst_b),
		.serialClk(serialClk), .chip_select_low(chip_select_low),
		.serialIn(serialIn), .serialOut(serialOut),
		.serialOutEn(serialOutEn), .oscRunning(oscRunning),
		.statusByte(status), .wrAcc(wrAcc), .wrValid(wrValid),
		.wrReady(wrReady), .rdAddr(rdAddr), .rdStrobe(rdStrobe),
		.rdData(rdData), .overrun(overrun));
	scp_host i_host (.core_clk(core_clk), .serialClk(serialClk),
		.chip_select_low(chip_select_low), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn));

	// Clock and watchdog
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		print_verdict();
	end
	// Core side: read data one cycle after the strobe, else garbage
	always @(posedge core_clk) begin
		if (!rst_b) begin
			rdData <= 8'h00;
		end else begin
			rdData <= rdStrobe ? ({2'h0, rdAddr} ^ 8'h5A) : ~rdData;
		end
		if (overrun === 1'b1) overruns++;
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [14:0] got, exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s %h/%h", $time, msg, got, exp);
		end
	endtask
	// Ready must come quickly while the oscillator runs
	task automatic start;
		i_host.openFrame(6, ok);
		if (!ok) begin
			miscompares++;
			print_verdict();
		end
	endtask
	// Take one write access from the FIFO under a bounded wait
	task automatic pop(input logic [14:0] exp);
		int i;
		for (i = 0; i < 50 && wrValid !== 1'b1; i++) @(posedge core_clk);
		chk(15'(wrValid), 15'h1, "valid");
		chk(wrAcc, exp, "access");
		wrReady <= 1'b1;
		@(posedge core_clk);
		wrReady <= 1'b0;
		@(posedge core_clk);
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		wrReady = 1'b0;
		oscRunning = 1'b0;
		status = 8'h2D;
		repeat (4) @(posedge core_clk);
		chk(15'({serialOutEn, wrValid, overrun}), 15'h0, "reset");
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		i_host.openFrame(12, ok);
		chk(15'(ok), 15'h0, "ready without osc");
		oscRunning <= 1'b1;
		i_host.openFrame(12, ok);
		chk(15'(ok), 15'h1, "ready with osc");
		i_host.shiftByte(8'h05, 8, rx);
		chk(15'(rx), 15'(status), "status");
		i_host.shiftByte(8'hA5, 8, rx);
		chk(15'(rx), 15'(status), "status data");
		i_host.closeFrame();
		pop({1'b0, 6'h05, 8'hA5});
		// Burst write of five with the core stalled
		start();
		i_host.shiftByte(8'h4C, 8, rx);
		for (int k = 0; k < 5; k++) begin
			i_host.shiftByte(8'h10 + 8'(k), 8, rx);
		end
		i_host.closeFrame();
		chk(15'(overruns), 15'h1, "overrun");
		for (int k = 0; k < 4; k++) begin
			pop({1'b0, 6'h0C + 6'(k), 8'h10 + 8'(k)});
		end
		chk(15'(wrValid), 15'h0, "drained");
		// Burst read of two under a new status, then a single read
		status <= 8'h1E;
		start();
		i_host.shiftByte(8'hCA, 8, rx);
		chk(15'(rx), 15'(status), "status read");
		for (int k = 0; k < 2; k++) begin
			i_host.shiftByte(8'h00, 8, rx);
			chk(15'(rx), 15'((8'h0A + 8'(k)) ^ 8'h5A), "burst read");
		end
		i_host.closeFrame();
		start();
		i_host.shiftByte(8'hBF, 8, rx);
		i_host.shiftByte(8'h00, 8, rx);
		chk(15'(rx), 15'(8'h3F ^ 8'h5A), "single read");
		i_host.closeFrame();
		// Abort inside a header, then inside a data byte
		start();
		i_host.shiftByte(8'h07, 4, rx);
		i_host.closeFrame();
		start();
		i_host.shiftByte(8'h12, 8, rx);
		i_host.shiftByte(8'h34, 4, rx);
		i_host.closeFrame();
		chk(15'(wrValid), 15'h0, "aborted");
		start();
		i_host.shiftByte(8'h03, 8, rx);
		i_host.shiftByte(8'h66, 8, rx);
		i_host.closeFrame();
		pop({1'b0, 6'h03, 8'h66});
		print_verdict();
	end
endmodule
